// ===== design/cpm_cfg.svh
// Purpose: constants of the compressor protection monitor
// Assumes: one slow tick of CPM_TICK_PERIOD_S seconds
// Notes: offsets are byte addresses
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

`define CPM_ADDR_HI_LIMIT 8'h00
`define CPM_ADDR_LO_LIMIT 8'h04
`define CPM_ADDR_HI_DELAY 8'h08
`define CPM_ADDR_LO_DELAY 8'h0C
`define CPM_ADDR_HEAD_OFF 8'h10
`define CPM_ADDR_HEAD_ON 8'h14
`define CPM_ADDR_HEAD_DELAY 8'h18
`define CPM_ADDR_LT_HEAD 8'h1C
`define CPM_ADDR_LT_DELAY 8'h20
`define CPM_ADDR_MAX_STARTS 8'h24
`define CPM_ADDR_CTRL 8'h28
`define CPM_ADDR_STAGE_ENABLE 8'h2C
`define CPM_ADDR_STATUS0 8'h30
`define CPM_ADDR_STATUS1 8'h34
`define CPM_ADDR_STATUS2 8'h38

`define CPM_RST_HI_LIMIT 12'hC00
`define CPM_RST_LO_LIMIT 12'h200
`define CPM_RST_DELAY 16'h003C
`define CPM_RST_HEAD_OFF 12'hA00
`define CPM_RST_HEAD_ON 12'h900
`define CPM_RST_LT_HEAD 12'hA00
`define CPM_RST_MAX_STARTS 8'h0A
`define CPM_RST_CTRL 16'h0000

`define CPM_SHORT_CODE 12'h010
`define CPM_OPEN_CODE 12'hFF0
`define CPM_TRIP_LIMIT 3'h5
`define CPM_LT_MAX_STARTS 8'h10
`define CPM_TICK_PERIOD_S 1
`define CPM_HOUR_S 3600
`define CPM_DAY_S 86400

`endif

// ===== design/cpm_pkg.sv
// Purpose: types of the compressor protection monitor
// Assumes: three medium and three low level compressors
// Notes: compressors 0..2 medium level, 3..5 low level
package cpm_pkg;
    typedef logic [5:0][11:0] cpm_head_t;

    typedef struct packed {
        logic [1:0] drive_fault;
        logic [5:0] too_many_starts;
        logic [5:0] comp_fault;
        logic [5:0] auto_lockout_message;
        logic [2:0] low_level_head_temp_message;
        logic [2:0] mt_head_msg;
        logic temp_low;
        logic temp_high;
        logic [1:0] prio_b;
        logic [1:0] prio_a;
        logic meas_err_b;
        logic meas_err_a;
    } cpm_msg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cpm_bus_t;
endpackage

// ===== design/cpm_monitor.sv
// Purpose: outlet sensor, head temperature, start and drive monitoring
// Assumes: i_tick is a one-cycle pulse from logic on i_sys_clk
// Notes: contact inputs are low active and come from pins
//
// Function
// - flag short/open per outlet sensor, own priority
// - control on sensor b, a while b faulty
// - high and low range messages after delays
// - no range messages on fan temp error
// - range messages never touch control outputs
// - medium head over limit trips compressor
// - medium head message after alarm delay
// - medium release only at re-enable level
// - five medium trips daily give permanent lockout unless the other two are locked out
// - low head trip, message if still hot
// - low release below limit, five trips lock unless the other two are locked out
// - overload, pressure switch or head is fault
// - speed drive enabled with first stage
// - rotation off maps compressor to same stage
// - rotation on swaps stages one and two
// - medium start gap is hour over max
// - low level fixed sixteen starts per hour
// - combined control counts, flags too many starts
// - drive error restores start limiting
// - drive fault inputs give drive messages
// - drive fault joined with first overload
`include "cpm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cpm_monitor #(
    parameter int unsigned P_TICKS_PER_HOUR =
        `CPM_HOUR_S / `CPM_TICK_PERIOD_S,
    parameter int unsigned P_TICKS_PER_DAY =
        `CPM_DAY_S / `CPM_TICK_PERIOD_S
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_tick,
    input wire logic [11:0] i_outlet_temp_input_a,
    input wire logic [11:0] i_outlet_temp_input_b,
    input wire logic i_fan_temp_err,
    input wire cpm_pkg::cpm_head_t i_head_temp,
    input wire logic [5:0] i_overload_n,
    input wire logic [5:0] i_hp_switch_n,
    input wire logic [1:0] i_speed_drive_fault_n,
    input wire logic [1:0] i_rotation_on,
    input wire logic [5:0] i_stage_req,
    input wire cpm_pkg::cpm_bus_t i_bus,
    output logic [15:0] o_rdata,
    output logic [5:0] o_stage_en,
    output logic [1:0] o_speed_drive_en,
    output logic [11:0] o_ctl_temp,
    output cpm_pkg::cpm_msg_t o_msg
);
    import cpm_pkg::*;

    logic [13:0] pin_meta_reg, pin_sync_reg;
    logic [5:0] overload, hp_trip, over, rel, fault, lock_reg, perm_reg;
    logic [5:0] manual_en, comp_start, start_ok, stage_next, too_many_reg;
    logic [5:0] head_msg_reg, head_cond;
    logic [1:0] drive_in;
    logic [11:0] hi_limit_reg, lo_limit_reg, head_off_reg, head_on_reg;
    logic [11:0] lt_head_reg, ctl_temp;
    logic [15:0] hi_delay_reg, lo_delay_reg, head_delay_reg, lt_delay_reg;
    logic [15:0] ctrl_reg, hi_tmr_reg, lo_tmr_reg;
    logic [7:0] max_starts_reg;
    logic [15:0] head_tmr_reg [6];
    logic [2:0] trips_reg [6];
    logic [16:0] gap_reg [6];
    logic [7:0] starts_reg [6];
    logic [16:0] day_cnt_reg, hour_cnt_reg;
    logic day_wrap, hour_wrap, err_a, err_b, hi_cond, lo_cond;
    logic hi_msg_reg, lo_msg_reg;
    logic [1:0] more_avail;
    cpm_msg_t msg_next;

    function automatic logic meas_bad(input logic [11:0] v);
        return (v < `CPM_SHORT_CODE) || (v > `CPM_OPEN_CODE);
    endfunction

    function automatic logic [15:0] tmr_next(input logic [15:0] t,
        input logic cond, input logic tick);
        if (!cond) begin
            return 16'h0000;
        end else if (tick && t != 16'hFFFF) begin
            return t + 16'h0001;
        end
        return t;
    endfunction

    function automatic int unsigned map_comp(input int unsigned s,
        input logic rot);
        int unsigned b;
        b = (s < 3) ? 0 : 3;
        if (rot && s == b) begin
            return b + 1;
        end else if (rot && s == b + 1) begin
            return b;
        end
        return s;
    endfunction

    function automatic logic [16:0] start_gap(input logic [7:0] n);
        logic [7:0] d;
        d = (n == 8'h00) ? 8'h01 : n;
        return 17'(P_TICKS_PER_HOUR / d);
    endfunction

    function automatic logic [1:0] popcnt3(input logic [2:0] v);
        return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction

    // contacts are asynchronous: two stages before use
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            pin_meta_reg <= 14'h3FFF;
            pin_sync_reg <= 14'h3FFF;
        end else begin
            pin_meta_reg <= {i_speed_drive_fault_n, i_hp_switch_n,
                i_overload_n};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign overload = ~pin_sync_reg[5:0];
    assign hp_trip = ~pin_sync_reg[11:6];
    assign drive_in = ~pin_sync_reg[13:12];

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            day_cnt_reg <= 17'h00000;
            hour_cnt_reg <= 17'h00000;
        end else if (i_tick) begin
            day_cnt_reg <= day_wrap ? 17'h00000 : day_cnt_reg + 17'h00001;
            hour_cnt_reg <= hour_wrap ? 17'h00000 :
                hour_cnt_reg + 17'h00001;
        end
    end

    assign day_wrap = i_tick &&
        (day_cnt_reg == 17'(P_TICKS_PER_DAY - 1));
    assign hour_wrap = i_tick &&
        (hour_cnt_reg == 17'(P_TICKS_PER_HOUR - 1));

    assign err_a = meas_bad(i_outlet_temp_input_a);
    assign err_b = meas_bad(i_outlet_temp_input_b);
    assign ctl_temp = err_b ? i_outlet_temp_input_a : i_outlet_temp_input_b;
    // range checks muted on fan temp error
    assign hi_cond = (ctl_temp > hi_limit_reg) && !i_fan_temp_err;
    assign lo_cond = (ctl_temp < lo_limit_reg) && !i_fan_temp_err;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            hi_tmr_reg <= 16'h0000;
            lo_tmr_reg <= 16'h0000;
            hi_msg_reg <= 1'b0;
            lo_msg_reg <= 1'b0;
        end else begin
            hi_tmr_reg <= tmr_next(hi_tmr_reg, hi_cond, i_tick);
            lo_tmr_reg <= tmr_next(lo_tmr_reg, lo_cond, i_tick);
            hi_msg_reg <= hi_cond && (hi_tmr_reg >= hi_delay_reg);
            lo_msg_reg <= lo_cond && (lo_tmr_reg >= lo_delay_reg);
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (i < 3) begin
                over[i] = i_head_temp[i] > head_off_reg;
                rel[i] = i_head_temp[i] <= head_on_reg;
                head_cond[i] = lock_reg[i];
            end else begin
                over[i] = i_head_temp[i] > lt_head_reg;
                rel[i] = i_head_temp[i] < lt_head_reg;
                head_cond[i] = lock_reg[i] && over[i];
            end
        end
    end

    assign more_avail[0] = popcnt3(~perm_reg[2:0]) > 2'h1;
    assign more_avail[1] = popcnt3(~perm_reg[5:3]) > 2'h1;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            lock_reg <= 6'h00;
            perm_reg <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                trips_reg[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (!lock_reg[i] && over[i]) begin
                    lock_reg[i] <= 1'b1;
                    if (trips_reg[i] == `CPM_TRIP_LIMIT - 3'h1 &&
                        more_avail[i / 3]) begin
                        perm_reg[i] <= 1'b1;
                        trips_reg[i] <= 3'h0;
                    end else begin
                        trips_reg[i] <= day_wrap ? 3'h1 :
                            trips_reg[i] + 3'h1;
                    end
                end else begin
                    // held until cool and not permanent
                    if (lock_reg[i] && rel[i] && !perm_reg[i]) begin
                        lock_reg[i] <= 1'b0;
                    end
                    if (day_wrap) begin
                        trips_reg[i] <= 3'h0;
                    end
                    if (manual_en[i]) begin
                        perm_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            head_msg_reg <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                head_tmr_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                head_tmr_reg[i] <= tmr_next(head_tmr_reg[i],
                    head_cond[i], i_tick);
                head_msg_reg[i] <= head_cond[i] && (head_tmr_reg[i] >=
                    ((i < 3) ? head_delay_reg : lt_delay_reg));
            end
        end
    end

    assign fault = overload | hp_trip | lock_reg;

    always_comb begin
        comp_start = 6'h00;
        stage_next = 6'h00;
        start_ok = 6'h00;
        for (int i = 0; i < 6; i++) begin
            start_ok[i] = (gap_reg[i] == 17'h00000) ||
                (ctrl_reg[0] && !drive_in[i / 3]);
        end
        for (int s = 0; s < 6; s++) begin
            stage_next[s] = i_stage_req[s] &&
                !fault[map_comp(s, i_rotation_on[s / 3])] &&
                (o_stage_en[s] ||
                 start_ok[map_comp(s, i_rotation_on[s / 3])]);
            comp_start[map_comp(s, i_rotation_on[s / 3])] =
                stage_next[s] && !o_stage_en[s];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            too_many_reg <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                gap_reg[i] <= 17'h00000;
                starts_reg[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (comp_start[i]) begin
                    gap_reg[i] <= start_gap((i < 3) ? max_starts_reg :
                        `CPM_LT_MAX_STARTS);
                end else if (i_tick && gap_reg[i] != 17'h00000) begin
                    gap_reg[i] <= gap_reg[i] - 17'h00001;
                end
                if (hour_wrap) begin
                    starts_reg[i] <= {7'h00, comp_start[i]};
                end else if (comp_start[i] && starts_reg[i] != 8'hFF) begin
                    starts_reg[i] <= starts_reg[i] + 8'h01;
                end
                if (starts_reg[i] > ((i < 3) ? max_starts_reg :
                    `CPM_LT_MAX_STARTS)) begin
                    too_many_reg[i] <= 1'b1;
                end else if (hour_wrap) begin
                    too_many_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        msg_next = '0;
        msg_next.meas_err_a = err_a;
        msg_next.meas_err_b = err_b;
        msg_next.prio_a = ctrl_reg[3:2];
        msg_next.prio_b = ctrl_reg[5:4];
        // report only, no path into stages
        msg_next.temp_high = hi_msg_reg;
        msg_next.temp_low = lo_msg_reg;
        msg_next.mt_head_msg = head_msg_reg[2:0];
        msg_next.low_level_head_temp_message = head_msg_reg[5:3];
        msg_next.auto_lockout_message = perm_reg;
        msg_next.comp_fault = fault;
        msg_next.too_many_starts = too_many_reg;
        msg_next.drive_fault = drive_in | {overload[3], overload[0]};
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_stage_en <= 6'h00;
            o_speed_drive_en <= 2'h0;
            o_ctl_temp <= 12'h000;
            o_msg <= '0;
        end else begin
            o_stage_en <= stage_next;
            o_speed_drive_en <= {stage_next[3], stage_next[0]};
            o_ctl_temp <= ctl_temp;
            o_msg <= msg_next;
        end
    end

    assign manual_en = (i_bus.wr &&
        i_bus.addr == `CPM_ADDR_STAGE_ENABLE) ? i_bus.wdata[5:0] : 6'h00;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            hi_limit_reg <= `CPM_RST_HI_LIMIT;
            lo_limit_reg <= `CPM_RST_LO_LIMIT;
            hi_delay_reg <= `CPM_RST_DELAY;
            lo_delay_reg <= `CPM_RST_DELAY;
            head_off_reg <= `CPM_RST_HEAD_OFF;
            head_on_reg <= `CPM_RST_HEAD_ON;
            head_delay_reg <= `CPM_RST_DELAY;
            lt_head_reg <= `CPM_RST_LT_HEAD;
            lt_delay_reg <= `CPM_RST_DELAY;
            max_starts_reg <= `CPM_RST_MAX_STARTS;
            ctrl_reg <= `CPM_RST_CTRL;
        end else if (i_bus.wr) begin
            if (i_bus.addr == `CPM_ADDR_HI_LIMIT) begin
                hi_limit_reg <= i_bus.wdata[11:0];
            end else if (i_bus.addr == `CPM_ADDR_LO_LIMIT) begin
                lo_limit_reg <= i_bus.wdata[11:0];
            end else if (i_bus.addr == `CPM_ADDR_HI_DELAY) begin
                hi_delay_reg <= i_bus.wdata;
            end else if (i_bus.addr == `CPM_ADDR_LO_DELAY) begin
                lo_delay_reg <= i_bus.wdata;
            end else if (i_bus.addr == `CPM_ADDR_HEAD_OFF) begin
                head_off_reg <= i_bus.wdata[11:0];
            end else if (i_bus.addr == `CPM_ADDR_HEAD_ON) begin
                head_on_reg <= i_bus.wdata[11:0];
            end else if (i_bus.addr == `CPM_ADDR_HEAD_DELAY) begin
                head_delay_reg <= i_bus.wdata;
            end else if (i_bus.addr == `CPM_ADDR_LT_HEAD) begin
                lt_head_reg <= i_bus.wdata[11:0];
            end else if (i_bus.addr == `CPM_ADDR_LT_DELAY) begin
                lt_delay_reg <= i_bus.wdata;
            end else if (i_bus.addr == `CPM_ADDR_MAX_STARTS) begin
                max_starts_reg <= i_bus.wdata[7:0];
            end else if (i_bus.addr == `CPM_ADDR_CTRL) begin
                ctrl_reg <= {10'h000, i_bus.wdata[5:0]};
            end
        end
    end

    // unmapped and write-only addresses read as zero
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
        end else if (!i_bus.rd) begin
            o_rdata <= 16'h0000;
        end else if (i_bus.addr == `CPM_ADDR_HI_LIMIT) begin
            o_rdata <= {4'h0, hi_limit_reg};
        end else if (i_bus.addr == `CPM_ADDR_LO_LIMIT) begin
            o_rdata <= {4'h0, lo_limit_reg};
        end else if (i_bus.addr == `CPM_ADDR_HI_DELAY) begin
            o_rdata <= hi_delay_reg;
        end else if (i_bus.addr == `CPM_ADDR_LO_DELAY) begin
            o_rdata <= lo_delay_reg;
        end else if (i_bus.addr == `CPM_ADDR_HEAD_OFF) begin
            o_rdata <= {4'h0, head_off_reg};
        end else if (i_bus.addr == `CPM_ADDR_HEAD_ON) begin
            o_rdata <= {4'h0, head_on_reg};
        end else if (i_bus.addr == `CPM_ADDR_HEAD_DELAY) begin
            o_rdata <= head_delay_reg;
        end else if (i_bus.addr == `CPM_ADDR_LT_HEAD) begin
            o_rdata <= {4'h0, lt_head_reg};
        end else if (i_bus.addr == `CPM_ADDR_LT_DELAY) begin
            o_rdata <= lt_delay_reg;
        end else if (i_bus.addr == `CPM_ADDR_MAX_STARTS) begin
            o_rdata <= {8'h00, max_starts_reg};
        end else if (i_bus.addr == `CPM_ADDR_CTRL) begin
            o_rdata <= ctrl_reg;
        end else if (i_bus.addr == `CPM_ADDR_STATUS0) begin
            o_rdata <= msg_next[15:0];
        end else if (i_bus.addr == `CPM_ADDR_STATUS1) begin
            o_rdata <= msg_next[31:16];
        end else if (i_bus.addr == `CPM_ADDR_STATUS2) begin
            o_rdata <= {2'h0, lock_reg, 6'h00, msg_next[33:32]};
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ===== sim/cpm_partner.sv
// Purpose: far side model: head sensors and fault contacts
// Assumes: trips commanded active high
// Notes: contacts open on a trip, so the pins read low
`timescale 1ns/100ps
`default_nettype none

module cpm_partner (
    input wire cpm_pkg::cpm_head_t i_head_set,
    input wire logic [5:0] i_ovl_trip,
    input wire logic [5:0] i_hp_trip,
    input wire logic [1:0] i_drv_trip,
    output cpm_pkg::cpm_head_t o_head_temp,
    output logic [5:0] o_overload_n,
    output logic [5:0] o_hp_switch_n,
    output logic [1:0] o_speed_drive_fault_n
);
    import cpm_pkg::*;
    assign o_head_temp = i_head_set;
    assign o_overload_n = ~i_ovl_trip;
    assign o_hp_switch_n = ~i_hp_trip;
    assign o_speed_drive_fault_n = ~i_drv_trip;
endmodule

`default_nettype wire

// ===== sim/cpm_monitor_checker.sv
// Purpose: port assertions of the protection monitor
// Assumes: head switch-off threshold keeps its reset value
// Notes: contact paths get four cycles for the synchronisers
`include "cpm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cpm_monitor_checker (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [11:0] i_outlet_temp_input_a,
    input wire logic [11:0] i_outlet_temp_input_b,
    input wire logic i_fan_temp_err,
    input wire cpm_pkg::cpm_head_t i_head_temp,
    input wire logic [5:0] i_overload_n,
    input wire logic [1:0] i_speed_drive_fault_n,
    input wire logic [1:0] i_rotation_on,
    input wire logic [5:0] o_stage_en,
    input wire logic [1:0] o_speed_drive_en,
    input wire logic [11:0] o_ctl_temp,
    input wire cpm_pkg::cpm_msg_t o_msg
);
    import cpm_pkg::*;
    logic [1:0] up_cnt;
    logic up, b_bad;
    // outputs are still zero just after reset release
    assign up = up_cnt == 2'h3;
    assign b_bad = i_outlet_temp_input_b < `CPM_SHORT_CODE ||
        i_outlet_temp_input_b > `CPM_OPEN_CODE;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            up_cnt <= 2'h0;
        end else if (!up) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence held_s(c);
        (up && c) [*4];
    endsequence
    sequence calm_s;
        (up && $stable(i_outlet_temp_input_a) &&
            $stable(i_outlet_temp_input_b)) [*2];
    endsequence
    drive_en_a: assert property (
        up |-> o_speed_drive_en == {o_stage_en[3], o_stage_en[0]})
        else $error("drive enable differs from first stage");
    ctl_sel_a: assert property (
        calm_s |-> o_ctl_temp == (b_bad ? i_outlet_temp_input_a :
            i_outlet_temp_input_b))
        else $error("wrong controlling outlet temperature");
    meas_b_a: assert property (
        held_s(b_bad) |-> o_msg.meas_err_b)
        else $error("sensor b fault not flagged");
    range_mute_a: assert property (
        held_s(i_fan_temp_err) |-> !o_msg.temp_high && !o_msg.temp_low)
        else $error("range message during fan sensor error");
    head_trip_a: assert property (
        up && i_head_temp[2] > `CPM_RST_HEAD_OFF
        |-> ##2 !o_stage_en[2] && o_msg.comp_fault[2])
        else $error("hot compressor not switched off");
    rot_off_a: assert property (
        held_s(!i_overload_n[0] && !i_rotation_on[0])
        |-> !o_stage_en[0] && o_msg.comp_fault[0])
        else $error("fault not mapped to own stage");
    rot_on_a: assert property (
        held_s(!i_overload_n[0] && i_rotation_on[0])
        |-> !o_stage_en[1] && o_msg.comp_fault[0])
        else $error("fault not mapped to swapped stage");
    drive_msg_a: assert property (
        held_s(!(i_speed_drive_fault_n[0] && i_overload_n[0]))
        |-> o_msg.drive_fault[0])
        else $error("drive fault message missing");
endmodule

bind cpm_monitor cpm_monitor_checker cpm_monitor_checker_i (
    .i_sys_clk, .i_reset_n, .i_outlet_temp_input_a,
    .i_outlet_temp_input_b, .i_fan_temp_err, .i_head_temp,
    .i_overload_n, .i_speed_drive_fault_n, .i_rotation_on,
    .o_stage_en, .o_speed_drive_en, .o_ctl_temp, .o_msg);

`default_nettype wire

// ===== sim/cpm_monitor_tb.sv
// Purpose: self-checking bench of the protection monitor
// Assumes: tick every eight clocks, short hour and day windows
// Notes: reads checked from a queue
`include "cpm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cpm_monitor_tb;
    import cpm_pkg::*;
    localparam int TK = 8;
    localparam logic [15:0] RV [12] = '{16'h0C00, 16'h0200,
        16'h003C, 16'h003C, 16'h0A00, 16'h0900, 16'h003C, 16'h0A00,
        16'h003C, 16'h000A, 16'h0000, 16'h0000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick = 1'b0;
    logic [2:0] tcnt = 3'h0;
    logic [11:0] tmp_a = 12'h800, tmp_b = 12'h800;
    logic fan_err = 1'b0;
    cpm_head_t head = {6{12'h800}};
    cpm_head_t head_w;
    logic [5:0] ovl = 6'h00, hp = 6'h00;
    logic [1:0] drv = 2'h0;
    logic [5:0] ovl_n, hp_n;
    logic [1:0] drv_n;
    logic [1:0] rot = 2'h0;
    logic [5:0] req = 6'h00;
    cpm_bus_t bus = '0;
    logic [15:0] rdata;
    logic [5:0] stage_en;
    logic [11:0] ctl_temp;
    cpm_msg_t msg;
    logic rd_d = 1'b0;
    logic [31:0] exp_q[$];
    int failures = 0;
    int total_checks = 0;
    int seed = 32'h671F4551;
    int k;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        tcnt <= tcnt + 3'h1;
        tick <= tcnt == 3'h7;
        rd_d <= bus.rd;
    end
    cpm_partner cpm_partner_i (.i_head_set(head), .i_ovl_trip(ovl),
        .i_hp_trip(hp), .i_drv_trip(drv), .o_head_temp(head_w),
        .o_overload_n(ovl_n), .o_hp_switch_n(hp_n),
        .o_speed_drive_fault_n(drv_n));
    cpm_monitor #(.P_TICKS_PER_HOUR(40), .P_TICKS_PER_DAY(2000))
        cpm_monitor_i (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_tick(tick), .i_outlet_temp_input_a(tmp_a),
        .i_outlet_temp_input_b(tmp_b), .i_fan_temp_err(fan_err),
        .i_head_temp(head_w), .i_overload_n(ovl_n),
        .i_hp_switch_n(hp_n), .i_speed_drive_fault_n(drv_n),
        .i_rotation_on(rot), .i_stage_req(req), .i_bus(bus),
        .o_rdata(rdata), .o_stage_en(stage_en),
        .o_speed_drive_en(), .o_ctl_temp(ctl_temp), .o_msg(msg));
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_port(input logic [15:0] got, input logic [15:0] e);
        total_checks++;
        if (got !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic cmp_rd(input logic [15:0] got, input logic [31:0] ent);
        cmp_port(got & ent[15:0], ent[31:16]);
    endtask
    // 1 ns past the edge: outputs settled
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
        input logic [15:0] m);
        exp_q.push_back({e, m});
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        wt(1);
    endtask
    always @(negedge clk) begin
        if (rd_d) begin
            cmp_rd(rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wt(2);
        for (k = 0; k < 12; k++) begin
            rd(8'(k * 4), RV[k], 16'hFFFF);
        end
        rd(8'h3C, 16'h0000, 16'hFFFF);
        wr(`CPM_ADDR_HI_DELAY, 16'h0004);
        wr(`CPM_ADDR_LO_DELAY, 16'h0004);
        wr(`CPM_ADDR_HEAD_DELAY, 16'h0002);
        wr(`CPM_ADDR_LT_DELAY, 16'h0002);
        wr(`CPM_ADDR_CTRL, 16'h0024);
        rd(`CPM_ADDR_CTRL, 16'h0024, 16'hFFFF);
        for (k = 0; k < 4; k++) begin
            tmp_a <= 12'h100 + 12'($random(seed) & 32'h7FF);
            tmp_b <= 12'h300 + 12'($random(seed) & 32'h7FF);
            wt(3);
            cmp_port(16'(ctl_temp), 16'(tmp_b));
        end
        tmp_b <= 12'h005;
        wt(3);
        cmp_port(16'(ctl_temp), 16'(tmp_a));
        rd(`CPM_ADDR_STATUS0, 16'h0026, 16'h003F);
        tmp_a <= 12'h008;
        tmp_b <= 12'hFF8;
        wt(3);
        rd(`CPM_ADDR_STATUS0, 16'h0027, 16'h003F);
        tmp_a <= 12'h800;
        tmp_b <= 12'hD00;
        wt(2 * TK);
        rd(`CPM_ADDR_STATUS0, 16'h0000, 16'h00C0);
        tmp_b <= 12'h800;
        wt(TK + 1);
        tmp_b <= 12'hD00;
        wt(2 * TK);
        rd(`CPM_ADDR_STATUS0, 16'h0000, 16'h00C0);
        wt(3 * TK);
        rd(`CPM_ADDR_STATUS0, 16'h0040, 16'h00C0);
        fan_err <= 1'b1;
        wt(4);
        rd(`CPM_ADDR_STATUS0, 16'h0000, 16'h00C0);
        fan_err <= 1'b0;
        tmp_b <= 12'h100;
        wt(6 * TK);
        rd(`CPM_ADDR_STATUS0, 16'h0080, 16'h00C0);
        tmp_b <= 12'h800;
        wr(`CPM_ADDR_CTRL, 16'h0025);
        req <= 6'h3F;
        wt(6 * TK);
        cmp_port(16'(stage_en), 16'h003F);
        for (k = 0; k < 5; k++) begin
            head[2] <= 12'hB00;
            wt(3 * TK);
            cmp_port(16'(stage_en[2]), 16'h0000);
            rd(`CPM_ADDR_STATUS0, 16'h0400, 16'h0400);
            head[2] <= 12'h950;
            wt(2 * TK);
            cmp_port(16'(stage_en[2]), 16'h0000);
            head[2] <= 12'h800;
            wt(2 * TK);
            cmp_port(16'(stage_en[2]), 16'(k < 4));
        end
        rd(`CPM_ADDR_STATUS1, 16'h0001, 16'h0001);
        wr(`CPM_ADDR_STAGE_ENABLE, 16'h0004);
        wt(2 * TK);
        cmp_port(16'(stage_en[2]), 16'h0001);
        rd(`CPM_ADDR_STATUS1, 16'h0000, 16'h0001);
        head[3] <= 12'hB00;
        wt(3 * TK);
        cmp_port(16'(stage_en[3]), 16'h0000);
        rd(`CPM_ADDR_STATUS0, 16'h0800, 16'h0800);
        head[3] <= 12'h9F0;
        wt(2 * TK);
        cmp_port(16'(stage_en[3]), 16'h0001);
        rd(`CPM_ADDR_STATUS0, 16'h0000, 16'h0800);
        for (k = 0; k < 2; k++) begin
            rot <= {2{k[0]}};
            ovl[0] <= 1'b1;
            wt(6);
            cmp_port(16'(stage_en[1:0]), k ? 16'h1 : 16'h2);
            rd(`CPM_ADDR_STATUS1, 16'h0010, 16'h0010);
            rd(`CPM_ADDR_STATUS2, 16'h0001, 16'h0003);
            ovl[0] <= 1'b0;
            wt(TK);
        end
        rot <= 2'h0;
        hp[4] <= 1'b1;
        wt(6);
        cmp_port(16'(stage_en[4]), 16'h0000);
        rd(`CPM_ADDR_STATUS1, 16'h0100, 16'h0100);
        hp[4] <= 1'b0;
        drv <= 2'h2;
        wt(6);
        rd(`CPM_ADDR_STATUS2, 16'h0002, 16'h0003);
        for (k = 0; k < 2; k++) begin
            req[3] <= 1'b0;
            wt(2);
            req[3] <= 1'b1;
            wt(4);
        end
        cmp_port(16'(stage_en[3]), 16'h0000);
        wt(3 * TK);
        cmp_port(16'(stage_en[3]), 16'h0001);
        drv <= 2'h0;
        wr(`CPM_ADDR_CTRL, 16'h0024);
        for (k = 0; k < 2; k++) begin
            req[1] <= 1'b0;
            wt(2);
            req[1] <= 1'b1;
            wt(TK);
        end
        cmp_port(16'(stage_en[1]), 16'h0000);
        wt(5 * TK);
        cmp_port(16'(stage_en[1]), 16'h0001);
        report_and_stop();
    end
endmodule

`default_nettype wire
